// >>> inc/flash_self_program_pkg.sv
// Contract
// - code protect low blocks external access, reads zero
// - cpu reads always proceed regardless of protection
// - self-writes only outside the guarded region
// - two-bit guard field selects protected block size
// - four user id words at 8000h-8003h
// - read trigger returns one word, two fetches ignored
// - programming performs no automatic erase
// - erase always covers one whole row
// - at most 32 words per programming operation
// - upper ten bits row, lower five latch
// - programming never spans two rows
// - latches reset to 3fff after write or erase
// - load or program only after complete unlock
// - latch-only set: unlock loads latch, no program
// - latch-only clear: load final latch, program row
// - unloaded latches stay blank during programming
package flash_self_program_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int WORD_W     = 14;
    localparam int ADDR_W     = 15;
    localparam int LATCH_W    = 5;
    localparam int ROW_W      = 10;
    localparam int NUM_LATCH  = 32;
    localparam int UID_NUM    = 4;
    localparam int UID_IDX_W  = 2;
    localparam int ADDR_HI_W  = 7;
    localparam int ADDR_LO_W  = 8;
    localparam int DATA_HI_W  = 6;
    localparam int DATA_LO_W  = 8;

    // blank value of an erased word and of an idle latch
    localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3fff;
    localparam logic [WORD_W-1:0] ZERO_WORD  = 14'h0000;

    // user id words sit at 8000h..8003h of config space
    localparam logic [ADDR_W:0]   UID_BASE   = 16'h8000;

    // ------------------------------------------------------------
    // guard field: first unguarded address, guard covers 0..top-1
    // ------------------------------------------------------------
    localparam logic [1:0]        GUARD_HALF    = 2'h0;
    localparam logic [1:0]        GUARD_QUARTER = 2'h1;
    localparam logic [1:0]        GUARD_BOOT    = 2'h2;
    localparam logic [1:0]        GUARD_NONE    = 2'h3;
    localparam logic [ADDR_W-1:0] TOP_HALF      = 15'h2000;
    localparam logic [ADDR_W-1:0] TOP_QUARTER   = 15'h1000;
    localparam logic [ADDR_W-1:0] TOP_BOOT      = 15'h0200;
    localparam logic [ADDR_W-1:0] TOP_NONE      = 15'h0000;

    // ------------------------------------------------------------
    // timing: fetches ignored after a read trigger
    // ------------------------------------------------------------
    localparam logic [1:0] READ_STALL = 2'h2;

    // ------------------------------------------------------------
    // control bits written by software
    // ------------------------------------------------------------
    typedef struct packed {
        logic write_allow;
        logic config_space_sel;
        logic latch_only_load;
        logic row_erase;
    } flash_ctrl_t;

    // row request towards the flash array
    typedef struct packed {
        logic [ROW_W-1:0]                    row;
        logic [NUM_LATCH-1:0][WORD_W-1:0]    data;
    } row_req_t;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_PROG  = 5'b00100,
        ST_ERASE = 5'b01000,
        ST_EXT   = 5'b10000
    } seq_state_t;

endpackage

// >>> rtl/write_latch_bank.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// write latch bank: one row worth of staging words
// ------------------------------------------------------------
module write_latch_bank
    import flash_self_program_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              load_en,
    input  wire logic [LATCH_W-1:0]                load_idx,
    input  wire logic [WORD_W-1:0]                 load_data,
    input  wire logic                              clear,
    output logic      [NUM_LATCH-1:0][WORD_W-1:0]  latch_q
);

    // one latch per word of the row, all flops
    genvar g;
    generate
        for (g = 0; g < NUM_LATCH; g = g + 1) begin : g_latch
            // clear wins: a load racing a completion is dropped, the row is done
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    latch_q[g] <= BLANK_WORD;
                end else if (clear) begin
                    latch_q[g] <= BLANK_WORD;
                end else if (load_en && load_idx == LATCH_W'(g)) begin
                    latch_q[g] <= load_data;
                end
            end
        end
    endgenerate

endmodule // write_latch_bank

// >>> rtl/flash_self_program_ctrl.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// program memory access and self-programming sequencer
// ------------------------------------------------------------
module flash_self_program_ctrl
    import flash_self_program_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // configuration word fields
    input  wire logic                  code_protect_n,
    input  wire logic [1:0]            self_write_guard_size,
    // cpu-side registers
    input  wire logic [ADDR_HI_W-1:0]  flash_addr_hi,
    input  wire logic [ADDR_LO_W-1:0]  flash_addr_lo,
    input  wire logic [DATA_HI_W-1:0]  flash_data_hi,
    input  wire logic [DATA_LO_W-1:0]  flash_data_lo,
    input  wire flash_ctrl_t           flash_ctrl,
    input  wire logic                  read_go,
    input  wire logic                  unlock_done,
    // cpu read answer and write status
    output logic [WORD_W-1:0]          read_word,
    output logic                       read_done,
    output logic                       fetch_ignore,
    output logic                       write_busy,
    output logic                       write_done,
    output logic                       write_refused,
    // flash array
    output logic                       flash_rd_en,
    output logic [ADDR_W-1:0]          flash_rd_addr,
    input  wire logic [WORD_W-1:0]     flash_rd_data,
    output logic                       flash_prog_req,
    output logic                       flash_erase_req,
    output logic [ROW_W-1:0]           flash_row,
    output logic [NUM_LATCH-1:0][WORD_W-1:0] flash_row_data,
    input  wire logic                  flash_op_done,
    // external programmer pins
    input  wire logic                  ext_rd_req,
    input  wire logic [ADDR_W-1:0]     ext_addr,
    output logic [WORD_W-1:0]          ext_rd_data,
    output logic                       ext_rd_valid
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic       rst_meta_n;   // first stage, read only by the second
    logic       rst_sync_n;   // reset copy used everywhere below

    // release through two flops, assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // external pin synchronisers
    // ------------------------------------------------------------
    logic                 ext_req_meta;  // first stage
    logic                 ext_req_sync;  // second stage
    logic                 ext_req_prev;  // edge history
    logic [ADDR_W-1:0]    ext_addr_meta; // first stage
    logic [ADDR_W-1:0]    ext_addr_sync; // second stage
    logic                 ext_req_rise;  // one cycle on request edge

    // pins come from the programmer's own timing, two flops each
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_req_meta  <= 1'b0;
            ext_req_sync  <= 1'b0;
            ext_req_prev  <= 1'b0;
            ext_addr_meta <= '0;
            ext_addr_sync <= '0;
        end else begin
            ext_req_meta  <= ext_rd_req;
            ext_req_sync  <= ext_req_meta;
            ext_req_prev  <= ext_req_sync;
            ext_addr_meta <= ext_addr;
            ext_addr_sync <= ext_addr_meta;
        end
    end

    // address must be steady two cycles before the request edge
    assign ext_req_rise = ext_req_sync & ~ext_req_prev;

    // ------------------------------------------------------------
    // address decode and guard
    // ------------------------------------------------------------
    logic [ADDR_W-1:0]    cpu_addr;     // full word address
    logic [WORD_W-1:0]    cpu_data;     // data register pair
    logic [ROW_W-1:0]     cpu_row;      // row part
    logic [LATCH_W-1:0]   cpu_latch;    // latch part
    logic [ADDR_W-1:0]    guard_top;    // first unguarded address
    logic                 in_guard;     // address is shielded
    logic                 uid_hit;      // config space user id word
    logic [UID_IDX_W-1:0] uid_idx;      // which id word

    assign cpu_addr  = {flash_addr_hi, flash_addr_lo};
    assign cpu_data  = {flash_data_hi, flash_data_lo};
    assign cpu_row   = cpu_addr[ADDR_W-1:LATCH_W];
    assign cpu_latch = cpu_addr[LATCH_W-1:0];
    assign uid_idx   = cpu_addr[UID_IDX_W-1:0];

    // guard size select; guarded block starts at address zero
    always_comb begin
        case (self_write_guard_size)
            GUARD_HALF:    guard_top = TOP_HALF;
            GUARD_QUARTER: guard_top = TOP_QUARTER;
            GUARD_BOOT:    guard_top = TOP_BOOT;
            default:       guard_top = TOP_NONE;
        endcase
    end

    assign in_guard = (cpu_addr < guard_top);

    // id words mirror 8000h..8003h; the high address bit is the space select
    assign uid_hit = flash_ctrl.config_space_sel &&
                     ({1'b1, cpu_addr} < (UID_BASE + 16'(UID_NUM)));

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    seq_state_t   state;        // current phase
    seq_state_t   next_state;   // phase for next edge
    logic [1:0]   stall_cnt;    // fetch cycles still ignored

    logic         unlock_ok;    // unlock accepted for a write action
    logic         do_load;      // put data into a latch
    logic         do_prog;      // start row program after the load
    logic         do_erase;     // start row erase
    logic         do_uid;       // write a user id word
    logic         op_finish;    // flash reports end of program/erase

    // an interrupted unlock never raises unlock_done, so nothing starts
    assign unlock_ok = unlock_done && flash_ctrl.write_allow &&
                       (state == ST_IDLE);
    assign do_uid    = unlock_ok && flash_ctrl.config_space_sel && uid_hit;
    assign do_erase  = unlock_ok && !flash_ctrl.config_space_sel &&
                       flash_ctrl.row_erase && !in_guard;
    assign do_load   = unlock_ok && !flash_ctrl.config_space_sel &&
                       !flash_ctrl.row_erase && !in_guard;
    assign do_prog   = do_load && !flash_ctrl.latch_only_load;
    assign op_finish = flash_op_done &&
                       (state == ST_PROG || state == ST_ERASE);

    // phase transitions
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (read_go) begin
                    next_state = ST_READ;
                end else if (do_prog) begin
                    next_state = ST_PROG;
                end else if (do_erase) begin
                    next_state = ST_ERASE;
                end else if (ext_req_rise) begin
                    next_state = ST_EXT;
                end
            end
            ST_READ: begin
                if (stall_cnt == 2'h1) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PROG, ST_ERASE: begin
                if (flash_op_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_EXT: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // cpu read path
    // ------------------------------------------------------------
    // the two fetches after the trigger are swallowed while the array answers
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stall_cnt    <= 2'h0;
            fetch_ignore <= 1'b0;
        end else if (state == ST_IDLE && read_go) begin
            stall_cnt    <= READ_STALL;
            fetch_ignore <= 1'b1;
        end else if (state == ST_READ) begin
            stall_cnt    <= stall_cnt - 2'h1;
            fetch_ignore <= (stall_cnt != 2'h1);
        end else begin
            fetch_ignore <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // flash read port, shared by cpu and programmer
    // ------------------------------------------------------------
    logic   rd_cfg;      // current cpu read targets config space
    logic   rd_uid;      // that read hits a user id word

    // cpu has priority; the programmer only gets an idle array
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flash_rd_en   <= 1'b0;
            flash_rd_addr <= '0;
            rd_cfg        <= 1'b0;
            rd_uid        <= 1'b0;
        end else if (state == ST_IDLE && read_go) begin
            flash_rd_en   <= !flash_ctrl.config_space_sel;
            flash_rd_addr <= cpu_addr;
            rd_cfg        <= flash_ctrl.config_space_sel;
            rd_uid        <= uid_hit;
        end else if (state == ST_IDLE && ext_req_rise) begin
            flash_rd_en   <= code_protect_n;
            flash_rd_addr <= ext_addr_sync;
        end else begin
            flash_rd_en   <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // user id words
    // ------------------------------------------------------------
    logic [UID_NUM-1:0][WORD_W-1:0] uid_word; // software-writable id store

    // written straight by an unlocked config-space write, no latch involved
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            uid_word <= {UID_NUM{BLANK_WORD}};
        end else if (do_uid) begin
            uid_word[uid_idx] <= cpu_data;
        end
    end

    // cpu answer: array word lands one cycle after the enable
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            read_word <= ZERO_WORD;
            read_done <= 1'b0;
        end else if (state == ST_READ && stall_cnt == 2'h1) begin
            // config space beyond the id words reads as zero here
            if (rd_cfg) begin
                read_word <= rd_uid ? uid_word[flash_rd_addr[UID_IDX_W-1:0]] : ZERO_WORD;
            end else begin
                read_word <= flash_rd_data;
            end
            read_done <= 1'b1;
        end else begin
            read_done <= 1'b0;
        end
    end

    logic   ext_pend;    // array word for the programmer is due now

    // programmer answer: protected parts read as all zeros; the array
    // answers a cycle after the enable, so the capture waits one cycle
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_pend     <= 1'b0;
            ext_rd_data  <= ZERO_WORD;
            ext_rd_valid <= 1'b0;
        end else begin
            ext_pend     <= (state == ST_EXT);
            ext_rd_valid <= ext_pend;
            if (ext_pend) begin
                ext_rd_data <= code_protect_n ? flash_rd_data : ZERO_WORD;
            end
        end
    end

    // ------------------------------------------------------------
    // write latches
    // ------------------------------------------------------------
    logic [NUM_LATCH-1:0][WORD_W-1:0] latch_q; // staged row image

    // index is only the low five bits, so a load can never leave the row
    write_latch_bank u_latches (
        .clk       (sys_clk),
        .rst_n     (rst_sync_n),
        .load_en   (do_load),
        .load_idx  (cpu_latch),
        .load_data (cpu_data),
        .clear     (op_finish),
        .latch_q   (latch_q)
    );

    // ------------------------------------------------------------
    // row program and erase requests
    // ------------------------------------------------------------
    // final word is folded in here since the bank only sees it next edge
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flash_prog_req  <= 1'b0;
            flash_erase_req <= 1'b0;
            flash_row       <= '0;
            flash_row_data  <= {NUM_LATCH{BLANK_WORD}};
        end else if (state == ST_IDLE && !read_go && do_prog) begin
            flash_prog_req  <= 1'b1;
            flash_row       <= cpu_row;
            flash_row_data  <= latch_q;
            flash_row_data[cpu_latch] <= cpu_data;
        end else if (state == ST_IDLE && !read_go && do_erase) begin
            flash_erase_req <= 1'b1;
            flash_row       <= cpu_row;
        end else if (op_finish) begin
            flash_prog_req  <= 1'b0;
            flash_erase_req <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status towards software
    // ------------------------------------------------------------
    // refused: an unlocked write that hit the guard, nothing was touched
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            write_busy    <= 1'b0;
            write_done    <= 1'b0;
            write_refused <= 1'b0;
        end else begin
            write_busy    <= (next_state == ST_PROG) || (next_state == ST_ERASE);
            write_done    <= op_finish || do_uid || (do_load && !do_prog);
            write_refused <= unlock_ok && !flash_ctrl.config_space_sel && in_guard;
        end
    end

endmodule // flash_self_program_ctrl

// >>> test/flash_self_program_ctrl_asserts.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// checker on the sequencer ports
// ------------------------------------------------------------
module flash_self_program_ctrl_asserts
    import flash_self_program_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 code_protect_n,
    input wire logic [ADDR_HI_W-1:0] flash_addr_hi,
    input wire logic [ADDR_LO_W-1:0] flash_addr_lo,
    input wire flash_ctrl_t          flash_ctrl,
    input wire logic                 unlock_done,
    input wire logic [WORD_W-1:0]    read_word,
    input wire logic                 read_done,
    input wire logic                 fetch_ignore,
    input wire logic                 write_busy,
    input wire logic                 write_done,
    input wire logic                 write_refused,
    input wire logic                 flash_rd_en,
    input wire logic [WORD_W-1:0]    flash_rd_data,
    input wire logic                 flash_prog_req,
    input wire logic                 flash_erase_req,
    input wire logic [ROW_W-1:0]     flash_row,
    input wire logic                 flash_op_done,
    input wire logic [WORD_W-1:0]    ext_rd_data,
    input wire logic                 ext_rd_valid
);
    // single clock domain
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ext_read_zero: assert property (ext_rd_valid && !code_protect_n |-> ext_rd_data == ZERO_WORD)
        else $error("protected read gave data");
    a_cpu_read_data: assert property (read_done && $past(flash_rd_en, 2)
        && !$past(flash_ctrl.config_space_sel, 3) |-> read_word == $past(flash_rd_data))
        else $error("cpu read word wrong");
    a_fetch_skip: assert property (flash_rd_en && fetch_ignore |=> fetch_ignore ##1 (read_done && !fetch_ignore))
        else $error("read answer misplaced");
    a_refuse_quiet: assert property (write_refused |-> $past(unlock_done) && !flash_prog_req && !write_done)
        else $error("guarded write not quiet");
    a_prog_unlocked: assert property ($rose(flash_prog_req) |-> $past(unlock_done)
        && $past(flash_ctrl.write_allow) && !$past(flash_ctrl.latch_only_load))
        else $error("program without final unlock");
    a_prog_row: assert property ($rose(flash_prog_req)
        |-> flash_row == {$past(flash_addr_hi), $past(flash_addr_lo[7:5])}) else $error("wrong program row");
    a_req_holds: assert property (flash_prog_req && !flash_op_done |=> flash_prog_req && write_busy)
        else $error("program request dropped");
    a_op_complete: assert property ((flash_prog_req || flash_erase_req) && flash_op_done
        |=> !flash_prog_req && !flash_erase_req && !write_busy && write_done) else $error("bad operation end");
    a_erase_row: assert property ($rose(flash_erase_req) |-> $past(flash_ctrl.row_erase) && !flash_prog_req)
        else $error("erase without erase select");
endmodule // flash_self_program_ctrl_asserts

bind flash_self_program_ctrl flash_self_program_ctrl_asserts checker_i (.*);

// >>> test/flash_self_program_ctrl_tb.sv
`timescale 1ns/100ps
module flash_self_program_ctrl_tb;
    import flash_self_program_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk, rst_n, code_protect_n, read_go, unlock_done, flash_op_done, ext_rd_req;
    logic read_done, fetch_ignore, write_busy, write_done, write_refused, flash_rd_en;
    logic flash_prog_req, flash_erase_req, ext_rd_valid;
    logic [1:0]                          self_write_guard_size;
    logic [ADDR_HI_W-1:0]                flash_addr_hi;
    logic [ADDR_LO_W-1:0]                flash_addr_lo;
    logic [DATA_HI_W-1:0]                flash_data_hi;
    logic [DATA_LO_W-1:0]                flash_data_lo;
    flash_ctrl_t                         flash_ctrl;
    logic [WORD_W-1:0]                   read_word, flash_rd_data, ext_rd_data;
    logic [ADDR_W-1:0]                   flash_rd_addr, ext_addr, t;
    logic [ROW_W-1:0]                    flash_row;
    logic [NUM_LATCH-1:0][WORD_W-1:0]    flash_row_data, exp_row;
    int                                  failures, compares, cycles;
    // control words {write_allow, config_space_sel, latch_only_load, row_erase}
    localparam logic [3:0] LOAD = 4'h2 | 4'h8, PROG = 4'h8, ERASE = 4'h9, IDW = 4'he, NOWA = 4'h2;
    localparam logic [ADDR_W-1:0] TOPS [3] = '{TOP_HALF, TOP_QUARTER, TOP_BOOT};

    flash_self_program_ctrl DUT (.*);

    always #10 sys_clk = ~sys_clk;
    // array stand-in: word is a scramble of its address, one cycle late
    always @(posedge sys_clk) if (flash_rd_en) flash_rd_data <= flash_rd_addr[13:0] ^ 14'h2a5a;
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // compare, access tasks and report
    // ------------------------------------------------------------
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // {done, refused, prog, erase}
    task automatic outs(input logic [3:0] exp);
        chk({10'h0, write_done, write_refused, flash_prog_req, flash_erase_req}, {10'h0, exp});
    endtask
    // registers and one unlock pulse, driven on the same edge
    task automatic unlock(input logic [14:0] a, input logic [13:0] d, input logic [3:0] c);
        @(posedge sys_clk);
        {flash_addr_hi, flash_addr_lo} <= a;
        {flash_data_hi, flash_data_lo} <= d;
        flash_ctrl <= c;
        unlock_done <= 1'b1;
        @(posedge sys_clk) unlock_done <= 1'b0;
        #1;
    endtask
    // array completion
    task automatic op_end;
        @(posedge sys_clk) flash_op_done <= 1'b1;
        @(posedge sys_clk) flash_op_done <= 1'b0;
        #1 chk({10'h0, write_done, write_busy, flash_prog_req, flash_erase_req}, 14'h0008);
    endtask
    task automatic cpu_read(input logic [14:0] a, input logic [3:0] c, input logic [13:0] e);
        @(posedge sys_clk);
        {flash_addr_hi, flash_addr_lo} <= a;
        flash_ctrl <= c;
        read_go <= 1'b1;
        @(posedge sys_clk) read_go <= 1'b0;
        @(posedge sys_clk) #1 chk({13'h0, fetch_ignore}, 14'h0001);
        @(posedge sys_clk) #1 chk({12'h0, read_done, fetch_ignore}, 14'h0002);
        chk(read_word, e);
    endtask
    // programmer read, address settled first
    task automatic ext_read(input logic [14:0] a, input logic [13:0] e);
        @(posedge sys_clk) ext_addr <= a;
        repeat (3) @(posedge sys_clk);
        ext_rd_req <= 1'b1;
        for (int i = 0; i < 8 && ext_rd_valid !== 1'b1; i++) @(posedge sys_clk) #1;
        chk({13'h0, ext_rd_valid}, 14'h0001);
        chk(ext_rd_data, e);
        @(posedge sys_clk) ext_rd_req <= 1'b0;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_clk, rst_n, read_go, unlock_done, flash_op_done, ext_rd_req} = '0;
        {flash_addr_hi, flash_addr_lo, flash_data_hi, flash_data_lo, ext_addr} = '0;
        {code_protect_n, self_write_guard_size, flash_ctrl} = 7'h7f;
        {failures, compares, cycles} = '0;
        exp_row = {NUM_LATCH{BLANK_WORD}};
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 chk(flash_row_data[31], BLANK_WORD);
        // per guard size: last guarded refused, first free loads
        for (int g = 0; g < 4; g++) begin
            @(posedge sys_clk) self_write_guard_size <= 2'(g);
            t = (g < 3) ? TOPS[g] : TOP_NONE;
            if (g < 3) begin
                unlock(t - 15'h1, 14'h0001, LOAD);
                outs(4'h4);
            end
            unlock(t, 14'(g + 16), LOAD);
            outs(4'h8);
            exp_row[0] = 14'(g + 16);
        end
        // partial row: latch 31 and final latch 5 of row 100h
        unlock(15'h201f, 14'h1f1f, LOAD);
        outs(4'h8);
        exp_row[31] = 14'h1f1f;
        exp_row[5] = 14'h0555;
        unlock(15'h2005, 14'h0555, PROG);
        outs(4'h2);
        chk({4'h0, flash_row}, 14'h0100);
        for (int i = 0; i < NUM_LATCH; i++) chk(flash_row_data[i], exp_row[i]);
        op_end();
        // single word: other latches blank again
        exp_row = {NUM_LATCH{BLANK_WORD}};
        exp_row[3] = 14'h0033;
        unlock(15'h2043, 14'h0033, PROG);
        chk({4'h0, flash_row}, 14'h0102);
        for (int i = 0; i < NUM_LATCH; i++) chk(flash_row_data[i], exp_row[i]);
        op_end();
        unlock(15'h2060, 14'h0000, ERASE);
        outs(4'h1);
        op_end();
        unlock(15'h2000, 14'h0007, NOWA);
        outs(4'h0);
        @(posedge sys_clk) self_write_guard_size <= GUARD_HALF;
        unlock(15'h0040, 14'h0007, PROG);
        outs(4'h4);
        // id words, then reads with code protection on and off
        unlock(15'h0002, 14'h1234, IDW);
        outs(4'h8);
        cpu_read(15'h0002, IDW, 14'h1234);
        cpu_read(15'h0003, IDW, BLANK_WORD);
        @(posedge sys_clk) code_protect_n <= 1'b0;
        cpu_read(15'h0123, LOAD, 14'h0123 ^ 14'h2a5a);
        ext_read(15'h0123, ZERO_WORD);
        @(posedge sys_clk) code_protect_n <= 1'b1;
        ext_read(15'h0456, 14'h0456 ^ 14'h2a5a);
        summarize();
    end
endmodule // flash_self_program_ctrl_tb
